// *** logic/ivt_interval_timer.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - counter runs up to FFFF, wraps to zero, the wrap raises overflow
// - each count is one microsecond of elapsed time
// - out_transfer_a stores the preset, kept for any number of reloads
// - out_transfer_c writes control, in_transfer_c reads it back
// - control bit 9 lets external trigger pulses load the preset
// - control bit 10 reloads the preset on every overflow
// - control bit 11 halts the counter on overflow
// - control bit 14 zeroes the counter at the auxiliary pulse, unless a bit 13 preset load overrides it
// - control bit 15 clear runs the counter, set holds it
// - control may be written at any time, running or not
// - bits 13 and 14 act only at the auxiliary pulse, bit 12 at the pulse and on in_transfer_a
// - every load takes the most recently written preset
// - bit 12 low and bit 13 high at the pulse load the preset
// - bit 12 high at the pulse captures the live count
// - in_transfer_a returns the sample only while bit 12 is set
// - sampling and reading never disturb the running counter
// - overflow interrupts only while busy is set
// - busy has no effect on counting, loading, zeroing or sampling
// - start sets busy, clears done and the pending interrupt
// - clear and global reset drop busy, done, interrupt; reset also mask
module ivt_interval_timer (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// device-addressed strobes from the host bus
	input wire logic i_dev_sel,
	input wire logic i_start,
	input wire logic i_clear,
	input wire logic i_pulse,
	input wire logic i_out_transfer_a,
	input wire logic i_out_transfer_c,
	input wire logic i_in_transfer_a,
	input wire logic i_in_transfer_c,
	input wire logic [ivt_pkg::DATA_W-1:0] i_data,
	// broadcast strobes
	input wire logic i_global_bus_reset,
	input wire logic i_mask_load,
	input wire logic i_mask_bit,
	// external load trigger pin
	input wire logic i_ext_trigger,
	// read data back to the host
	output logic [ivt_pkg::DATA_W-1:0] o_data,
	output logic o_data_valid,
	// busy/done flags and interrupt request
	output logic o_busy,
	output logic o_done,
	output logic o_int_req
);
	typedef struct packed {
		logic [ivt_pkg::CTRL_W-1:0] ctrl;
		logic [ivt_pkg::DATA_W-1:0] preset;
		logic [ivt_pkg::DATA_W-1:0] cnt;
		logic [ivt_pkg::DATA_W-1:0] sample;
		logic [ivt_pkg::DATA_W-1:0] rdata;
		logic rvalid;
		logic busy;
		logic done;
		logic mask;
		logic int_req;
		logic trig_meta;
		logic trig_sync;
		logic trig_prev;
	} ivt_state_t;

	ivt_state_t state_reg;
	ivt_state_t state_next;

	logic tick;
	logic sel_out_a;
	logic sel_out_c;
	logic sel_in_a;
	logic sel_in_c;
	logic p_hit;
	logic start_hit;
	logic clear_hit;
	logic ext_edge;
	logic ext_load;
	logic running;
	logic ovf;
	logic [ivt_pkg::DATA_W-1:0] preset_now;

	// full control word: bits 0..8 of the word are unused and read zero
	function automatic logic [ivt_pkg::DATA_W-1:0] ctrl_word(
		input logic [ivt_pkg::CTRL_W-1:0] c
	);
		ctrl_word = {ivt_pkg::CTRL_UNUSED_READ, c};
	endfunction

	ivt_tick_gen u_ivt_tick_gen (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.o_tick(tick)
	);

	assign sel_out_a = i_dev_sel & i_out_transfer_a;
	assign sel_out_c = i_dev_sel & i_out_transfer_c;
	assign sel_in_a = i_dev_sel & i_in_transfer_a;
	assign sel_in_c = i_dev_sel & i_in_transfer_c;
	assign p_hit = i_dev_sel & i_pulse;
	assign start_hit = i_dev_sel & i_start;
	assign clear_hit = i_dev_sel & i_clear;
	// edge taken after the synchroniser, never from its first stage
	assign ext_edge = state_reg.trig_sync & ~state_reg.trig_prev;
	assign ext_load = ext_edge & state_reg.ctrl[ivt_pkg::CTRL_EXT_LOAD];
	assign running = ~state_reg.ctrl[ivt_pkg::CTRL_STOP];
	assign ovf = tick & running & (state_reg.cnt == ivt_pkg::COUNT_MAX);
	// a preset written in the same cycle as a load is already the latest one
	assign preset_now = sel_out_a ? i_data : state_reg.preset;

	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		state_next.trig_meta = i_ext_trigger;
		state_next.trig_sync = state_reg.trig_meta;
		state_next.trig_prev = state_reg.trig_sync;

		if (sel_out_a) begin
			state_next.preset = i_data;
		end
		if (sel_out_c) begin
			state_next.ctrl = i_data[ivt_pkg::CTRL_W-1:0];
		end

		// counting on the microsecond enable, busy plays no part here
		if (tick && running) begin
			if (ovf) begin
				if (state_reg.ctrl[ivt_pkg::CTRL_OVF_LOAD]) begin
					state_next.cnt = preset_now;
				end else begin
					state_next.cnt = ivt_pkg::COUNT_ZERO;
				end
				if (state_reg.ctrl[ivt_pkg::CTRL_OVF_STOP]) begin
					// hardware stop wins over a host write in the same cycle
					state_next.ctrl[ivt_pkg::CTRL_STOP] = 1'b1;
				end
			end else begin
				state_next.cnt = state_reg.cnt + ivt_pkg::COUNT_STEP;
			end
		end

		if (ext_load) begin
			state_next.cnt = preset_now;
		end

		// bits 13..14 only act here, bit 12 also at the read; control as it stood before this cycle
		if (p_hit) begin
			if (state_reg.ctrl[ivt_pkg::CTRL_ZERO]) begin
				state_next.cnt = ivt_pkg::COUNT_ZERO;
			end
			if (state_reg.ctrl[ivt_pkg::CTRL_READ_SEL]) begin
				// capture leaves the count path untouched
				state_next.sample = state_reg.cnt;
			end else if (state_reg.ctrl[ivt_pkg::CTRL_LOAD]) begin
				state_next.cnt = preset_now;
			end
		end

		if (start_hit) begin
			state_next.busy = 1'b1;
			state_next.done = 1'b0;
		end
		if (clear_hit || i_global_bus_reset) begin
			state_next.busy = 1'b0;
			state_next.done = 1'b0;
		end
		if (i_mask_load) begin
			state_next.mask = i_mask_bit;
		end
		if (i_global_bus_reset) begin
			state_next.mask = 1'b0;
		end
		// overflow is an event: it wins over start or clear in the same cycle
		if (ovf && state_reg.busy) begin
			state_next.busy = 1'b0;
			state_next.done = 1'b1;
		end
		state_next.int_req = state_next.done & ~state_next.mask;

		if (sel_in_a) begin
			state_next.rvalid = 1'b1;
			if (state_reg.ctrl[ivt_pkg::CTRL_READ_SEL]) begin
				state_next.rdata = state_reg.sample;
			end else begin
				state_next.rdata = ivt_pkg::READ_INVALID;
			end
		end else if (sel_in_c) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = ctrl_word(state_reg.ctrl);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg.ctrl <= ivt_pkg::CTRL_RESET;
			state_reg.preset <= ivt_pkg::PRESET_RESET;
			state_reg.cnt <= ivt_pkg::COUNT_RESET;
			state_reg.sample <= ivt_pkg::SAMPLE_RESET;
			state_reg.rdata <= ivt_pkg::READ_INVALID;
			state_reg.rvalid <= 1'b0;
			state_reg.busy <= 1'b0;
			state_reg.done <= 1'b0;
			state_reg.mask <= 1'b0;
			state_reg.int_req <= 1'b0;
			state_reg.trig_meta <= 1'b0;
			state_reg.trig_sync <= 1'b0;
			state_reg.trig_prev <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_data = state_reg.rdata;
	assign o_data_valid = state_reg.rvalid;
	assign o_busy = state_reg.busy;
	assign o_done = state_reg.done;
	assign o_int_req = state_reg.int_req;

	chk_wrap_to_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ovf && !state_reg.ctrl[ivt_pkg::CTRL_OVF_LOAD] && !ext_load && !p_hit)
		|=> state_reg.cnt == ivt_pkg::COUNT_ZERO)
		else $error("counter did not wrap to zero");

	chk_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(tick && running && !ovf && !ext_load && !p_hit)
		|=> state_reg.cnt == $past(state_reg.cnt) + ivt_pkg::COUNT_STEP)
		else $error("counter did not advance by one on the tick");

	chk_preset_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		sel_out_a ##1 !sel_out_a [*3] |-> state_reg.preset == $past(i_data, 3))
		else $error("preset not retained");

	chk_ctrl_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(sel_in_c && !sel_in_a)
		|=> o_data_valid && o_data == ctrl_word($past(state_reg.ctrl)))
		else $error("control read returned wrong word");

	chk_ext_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ext_load && !p_hit) |=> state_reg.cnt == $past(preset_now))
		else $error("external trigger did not load preset");

	chk_ext_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ext_edge && !state_reg.ctrl[ivt_pkg::CTRL_EXT_LOAD] && !p_hit && !tick)
		|=> $stable(state_reg.cnt))
		else $error("external trigger acted while disabled");

	chk_ovf_reload: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ovf && state_reg.ctrl[ivt_pkg::CTRL_OVF_LOAD] && !ext_load && !p_hit)
		|=> state_reg.cnt == $past(preset_now))
		else $error("overflow did not reload preset");

	chk_ovf_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ovf && state_reg.ctrl[ivt_pkg::CTRL_OVF_STOP])
		|=> state_reg.ctrl[ivt_pkg::CTRL_STOP])
		else $error("counter not halted on overflow");

	chk_pulse_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(p_hit && state_reg.ctrl[ivt_pkg::CTRL_ZERO]
		&& (state_reg.ctrl[ivt_pkg::CTRL_READ_SEL] || !state_reg.ctrl[ivt_pkg::CTRL_LOAD]))
		|=> state_reg.cnt == ivt_pkg::COUNT_ZERO)
		else $error("pulse did not zero the counter");

	chk_stop_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(!running && !ext_load && !p_hit) |=> $stable(state_reg.cnt))
		else $error("stopped counter moved");

	chk_pulse_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(p_hit && !state_reg.ctrl[ivt_pkg::CTRL_READ_SEL] && state_reg.ctrl[ivt_pkg::CTRL_LOAD])
		|=> state_reg.cnt == $past(preset_now))
		else $error("pulse did not load preset");

	chk_sample_read: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(p_hit && state_reg.ctrl[ivt_pkg::CTRL_READ_SEL] && !sel_out_c)
		##1 (!p_hit && !sel_out_c) ##1 (sel_in_a && !p_hit)
		|=> o_data == $past(state_reg.cnt, 3))
		else $error("sampled count not returned");

	chk_sample_free: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(p_hit && state_reg.ctrl[ivt_pkg::CTRL_READ_SEL]
		&& !state_reg.ctrl[ivt_pkg::CTRL_ZERO] && !ext_load && !ovf)
		|=> state_reg.cnt == $past(state_reg.cnt) + {15'h0000, $past(tick && running)})
		else $error("sampling disturbed the counter");

	chk_busy_done: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ovf && state_reg.busy)
		|=> !o_busy && o_done && (o_int_req == !state_reg.mask))
		else $error("overflow did not complete busy/done");

	chk_idle_ovf: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(ovf && !state_reg.busy && !state_reg.done && !start_hit) |=> !o_done)
		else $error("overflow raised done without busy");

	chk_start: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(start_hit && !clear_hit && !i_global_bus_reset && !ovf)
		|=> o_busy && !o_done && !o_int_req)
		else $error("start did not set busy and clear done");

	chk_reset_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_global_bus_reset && !(ovf && state_reg.busy))
		|=> !o_busy && !o_done && !o_int_req && !state_reg.mask)
		else $error("global reset did not clear flags and mask");
endmodule

// *** logic/ivt_pkg.sv ***
package ivt_pkg;
	// data path width of the programmed I/O bus
	localparam int DATA_W = 16;
	// control bits 9..15 are stored; word bit 0 is the most significant
	localparam int CTRL_W = 7;
	localparam int CTRL_EXT_LOAD = 6;
	localparam int CTRL_OVF_LOAD = 5;
	localparam int CTRL_OVF_STOP = 4;
	localparam int CTRL_READ_SEL = 3;
	localparam int CTRL_LOAD = 2;
	localparam int CTRL_ZERO = 1;
	localparam int CTRL_STOP = 0;
	localparam logic [8:0] CTRL_UNUSED_READ = 9'h000;
	// reset values and count constants
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h01;
	localparam logic [DATA_W-1:0] PRESET_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] SAMPLE_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_MAX = 16'hFFFF;
	localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;
	localparam logic [DATA_W-1:0] READ_INVALID = 16'h0000;
	// timing: one count per microsecond, as a 16 MHz reference divided by 16
	localparam int REF_CLK_MHZ = 16;
	localparam int REF_DIV = 16;
	localparam int TICK_NS = REF_DIV * 1000 / REF_CLK_MHZ;
	localparam int SYS_CLK_MHZ = 125;
	localparam int TICK_CYC = TICK_NS * SYS_CLK_MHZ / 1000;
	localparam int TICK_CNT_W = 7;
	localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYC - 1);
	localparam logic [TICK_CNT_W-1:0] TICK_CNT_RESET = 7'h00;
	localparam logic [TICK_CNT_W-1:0] TICK_CNT_STEP = 7'h01;
endpackage

// *** logic/ivt_tick_gen.sv ***
`timescale 1ns/1ps
module ivt_tick_gen (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// one-cycle pulse per microsecond
	output logic o_tick
);
	typedef struct packed {
		logic [ivt_pkg::TICK_CNT_W-1:0] cnt;
		logic tick;
	} ivt_tick_state_t;

	ivt_tick_state_t state_reg;
	ivt_tick_state_t state_next;

	// free running, so the microsecond grid never shifts with host activity
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.cnt == ivt_pkg::TICK_LAST) begin
			state_next.cnt = ivt_pkg::TICK_CNT_RESET;
			state_next.tick = 1'b1;
		end else begin
			state_next.cnt = state_reg.cnt + ivt_pkg::TICK_CNT_STEP;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg.cnt <= ivt_pkg::TICK_CNT_RESET;
			state_reg.tick <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_tick = state_reg.tick;

	chk_tick_period: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		state_reg.tick |-> ##125 state_reg.tick)
		else $error("microsecond tick period is not 125 cycles");

	chk_tick_single: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		state_reg.tick |=> !state_reg.tick [*8])
		else $error("microsecond tick lasts more than one cycle");
endmodule

// *** test/ivt_host_model.sv ***
`timescale 1ns/1ps
module ivt_host_model (
	// clock
	input wire logic i_clk_sys,
	// read answer from the timer
	input wire logic [ivt_pkg::DATA_W-1:0] i_data,
	input wire logic i_data_valid,
	// strobes: start clear pulse oa oc ia ic reset mask ext
	output logic o_dev_sel,
	output logic [9:0] o_strobe,
	output logic [ivt_pkg::DATA_W-1:0] o_data
);
	initial begin
		o_dev_sel = 1'b0;
		o_strobe = 10'h000;
		o_data = 16'h0000;
	end
	// released data goes to its inverse so a stale word never looks valid
	task automatic op(input int k, input logic [15:0] d, input logic sel,
		output logic [15:0] q);
		@(posedge i_clk_sys);
		o_strobe <= 10'h001 << k;
		o_data <= d;
		o_dev_sel <= sel;
		@(posedge i_clk_sys);
		o_strobe <= 10'h000;
		o_dev_sel <= 1'b0;
		o_data <= ~d;
		#1;
		q = (i_data_valid === 1'b1) ? i_data : 16'hXXXX;
	endtask
	// interval of t counts: preset is the negated count, loaded while stopped
	task automatic arm(input logic [15:0] t);
		logic [15:0] q;
		op(3, 16'h0000 - t, 1'b1, q);
		op(4, 16'h0005, 1'b1, q);
		op(2, 16'h0000, 1'b1, q);
	endtask
	// read select stays set through the read
	task automatic samp(output logic [15:0] q);
		op(4, 16'h0009, 1'b1, q);
		op(2, 16'h0000, 1'b1, q);
		op(5, 16'h0000, 1'b1, q);
	endtask
endmodule

// *** test/ivt_interval_timer_test.sv ***
`timescale 1ns/1ps
module ivt_interval_timer_test;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic dev_sel;
	logic [9:0] stb;
	logic [15:0] hdata;
	logic [15:0] rdata;
	logic rvalid;
	logic busy;
	logic done;
	logic int_req;
	logic [15:0] q;
	logic [15:0] q1;
	int failures = 0;
	int tests_run = 0;
	int n;
	always #4 i_clk_sys = ~i_clk_sys;
	ivt_host_model u_ivt_host_model (.i_clk_sys(i_clk_sys), .i_data(rdata),
		.i_data_valid(rvalid), .o_dev_sel(dev_sel), .o_strobe(stb), .o_data(hdata));
	ivt_interval_timer u_ivt_interval_timer (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_dev_sel(dev_sel), .i_start(stb[0]), .i_clear(stb[1]), .i_pulse(stb[2]),
		.i_out_transfer_a(stb[3]), .i_out_transfer_c(stb[4]),
		.i_in_transfer_a(stb[5]), .i_in_transfer_c(stb[6]), .i_data(hdata),
		.i_global_bus_reset(stb[7]), .i_mask_load(stb[8]), .i_mask_bit(hdata[0]),
		.i_ext_trigger(stb[9]), .o_data(rdata), .o_data_valid(rvalid),
		.o_busy(busy), .o_done(done), .o_int_req(int_req));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic op(input int k, input logic [15:0] d);
		u_ivt_host_model.op(k, d, 1'b1, q);
	endtask
	function automatic logic [15:0] flags();
		return {13'h0000, busy, done, int_req};
	endfunction
	// bounded wait for the overflow to land
	task automatic wait_done();
		n = 0;
		while (done !== 1'b1 && n < 1000) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		failures++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		op(6, 16'h0000);
		chk(q, 16'h0001, "control after reset");
		op(4, 16'hFF7E);
		op(6, 16'h0000);
		chk(q, 16'h007E, "control readback");
		u_ivt_host_model.op(4, 16'h0000, 1'b0, q);
		op(6, 16'h0000);
		chk(q, 16'h007E, "unselected write ignored");
		op(4, 16'h0001);
		$display("test control done");
		u_ivt_host_model.arm(16'h0003);
		u_ivt_host_model.samp(q);
		chk(q, 16'hFFFD, "preset loaded and sampled");
		op(4, 16'h0001);
		op(5, 16'h0000);
		chk(q, 16'h0000, "sample read without select");
		op(0, 16'h0000);
		chk(flags(), 16'h0004, "start flags");
		op(4, 16'h0000);
		wait_done();
		chk({15'h0000, n > 2 * ivt_pkg::TICK_CYC && n <= 3 * ivt_pkg::TICK_CYC + 2},
			16'h0001, "interval length");
		chk(flags(), 16'h0003, "overflow flags");
		op(6, 16'h0000);
		chk(q, 16'h0000, "still running after overflow");
		op(4, 16'h0008);
		op(2, 16'h0000);
		op(5, 16'h0000);
		q1 = q;
		// pulses exactly one tick period apart see exactly one count
		repeat (ivt_pkg::TICK_CYC - 4) @(posedge i_clk_sys);
		op(2, 16'h0000);
		op(5, 16'h0000);
		chk(q, q1 + 16'h0001, "sampling leaves counter running");
		$display("test interval done");
		op(1, 16'h0000);
		chk(flags(), 16'h0000, "clear flags");
		u_ivt_host_model.arm(16'h0002);
		op(0, 16'h0000);
		op(4, 16'h0030);
		wait_done();
		op(6, 16'h0000);
		chk(q, 16'h0031, "stop on overflow");
		u_ivt_host_model.samp(q);
		chk(q, 16'hFFFE, "reload on overflow");
		$display("test reload done");
		u_ivt_host_model.arm(16'h0001);
		op(8, 16'h0001);
		op(0, 16'h0000);
		op(4, 16'h0020);
		wait_done();
		chk(flags(), 16'h0002, "masked overflow");
		op(7, 16'h0000);
		chk(flags(), 16'h0000, "global reset flags");
		// reload keeps overflowing every tick, busy is clear so nothing may show
		repeat (130) @(posedge i_clk_sys);
		#1;
		chk(flags(), 16'h0000, "no interrupt without busy");
		op(0, 16'h0000);
		wait_done();
		chk(flags(), 16'h0003, "mask cleared by global reset");
		op(4, 16'h0001);
		$display("test mask done");
		op(3, 16'h1234);
		op(4, 16'h0041);
		op(9, 16'h0000);
		repeat (6) @(posedge i_clk_sys);
		u_ivt_host_model.samp(q);
		chk(q, 16'h1234, "external load");
		op(3, 16'h5555);
		op(9, 16'h0000);
		repeat (6) @(posedge i_clk_sys);
		op(4, 16'h0003);
		repeat (2) @(posedge i_clk_sys);
		u_ivt_host_model.samp(q);
		chk(q, 16'h1234, "trigger ignored, zero waits for pulse");
		op(4, 16'h0003);
		op(2, 16'h0000);
		u_ivt_host_model.samp(q);
		chk(q, 16'h0000, "zero at pulse");
		$display("test trigger done");
		close_out();
	end
endmodule
